// ---- hdl/csi2_framer_defs.svh ----
// offsets, field positions, reset values and timing counts of the sample framer
`ifndef CSI2_FRAMER_DEFS_SVH
`define CSI2_FRAMER_DEFS_SVH

// ----------------------------------------------------------------------------
// clock and timing
// ----------------------------------------------------------------------------
`define CLK_FREQ_MHZ     100
`define WAKE_TIME_NS     2000
`define REF_HALF_CYCLES  4

// ----------------------------------------------------------------------------
// lane rate window in Mbps
// ----------------------------------------------------------------------------
`define RATE_MIN_MBPS    10'h096
`define RATE_MAX_MBPS    10'h258

// ----------------------------------------------------------------------------
// packet data types
// ----------------------------------------------------------------------------
`define DT_FRAME_START   6'h00
`define DT_FRAME_END     6'h01
`define DT_LINE_START    6'h02
`define DT_LINE_END      6'h03
`define DT_RAW12         6'h2c

// ----------------------------------------------------------------------------
// header ecc parity masks over {data_hi, data_lo, di}
// ----------------------------------------------------------------------------
`define ECC_P0           24'hf1_2cb7
`define ECC_P1           24'hf2_555b
`define ECC_P2           24'h74_9a6d
`define ECC_P3           24'hb8_e38e
`define ECC_P4           24'hdf_03f0
`define ECC_P5           24'hef_fc00

// ----------------------------------------------------------------------------
// payload checksum
// ----------------------------------------------------------------------------
`define CRC_INIT         16'hffff
`define CRC_POLY         16'h8408

// ----------------------------------------------------------------------------
// chirp header word layout
// ----------------------------------------------------------------------------
`define HDR_CH_LSB       0
`define HDR_CH_MSB       1
`define HDR_PROF_LSB     6
`define HDR_PROF_MSB     11

`endif

// ---- hdl/csi2_framer_pkg.sv ----
// types shared by the sample framer
package csi2_framer_pkg;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_FS   = 3'b001,
    S_LS   = 3'b010,
    S_LHDR = 3'b011,
    S_PAY  = 3'b100,
    S_CRC  = 3'b101,
    S_LE   = 3'b110,
    S_FE   = 3'b111
  } pkt_state_e;

  typedef enum logic [1:0] {
    SEC_HDR = 2'b00,
    SEC_SMP = 2'b01,
    SEC_CQ  = 2'b10
  } sect_e;

endpackage

// ---- hdl/csi2_sample_fifo.sv ----
// sample fifo with valid/ready on both sides
`timescale 1ns/100ps
module csi2_sample_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 8
) (
  input  wire logic             clock_in,
  input  wire logic             reset_n_in,
  input  wire logic             in_valid_in,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  in_ready_out,
  output logic                  out_valid_out,
  output logic [WIDTH-1:0]      out_data_out,
  input  wire logic             out_ready_in
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_ff, rd_ptr_ff, nxt_wr_ptr, nxt_rd_ptr;
  logic [AW:0]      count_ff, nxt_count;
  logic             ready_ff, nxt_ready;
  logic             push, pop;

  assign push          = in_valid_in && ready_ff;
  assign pop           = out_ready_in && (count_ff != '0);
  assign in_ready_out  = ready_ff;
  assign out_valid_out = (count_ff != '0);
  assign out_data_out  = mem[rd_ptr_ff];

  always_comb begin
    nxt_wr_ptr = push ? AW'(wr_ptr_ff + 1'b1) : wr_ptr_ff;
    nxt_rd_ptr = pop ? AW'(rd_ptr_ff + 1'b1) : rd_ptr_ff;
    nxt_count  = count_ff + (AW+1)'(push) - (AW+1)'(pop);
    nxt_ready  = (nxt_count != (AW+1)'(DEPTH));
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      wr_ptr_ff <= '0;
      rd_ptr_ff <= '0;
      count_ff  <= '0;
      ready_ff  <= 1'b1;
    end else begin
      wr_ptr_ff <= nxt_wr_ptr;
      rd_ptr_ff <= nxt_rd_ptr;
      count_ff  <= nxt_count;
      ready_ff  <= nxt_ready;
    end
  end

  always_ff @(posedge clock_in) begin
    if (push) begin
      mem[wr_ptr_ff] <= in_data_in;
    end
  end

endmodule // csi2_sample_fifo

// ---- hdl/radar_adc_csi2_framer.sv ----
// radar sample framer: sync packets, chirp payloads, lane distribution, sideband
`timescale 1ns/100ps
`include "csi2_framer_defs.svh"

// What this block does
// [RQ1] lanes run only when the set per-lane rate lies within 150 to 600 Mbps
// [RQ2] each frame opens with a frame-start and closes with a frame-end short packet
// [RQ3] each chirp line sits between line-start and line-end short packets
// [RQ4] payload order: chirp profile, chirp number, samples, then optional quality data
// [RQ5] payload opens with one header pair per channel: index, profile, chirp number
// [RQ6] samples of all four channels are interleaved, not sent channel after channel
// [RQ7] per sample index: I then Q of channel 0, then channels 1, 2, 3
// [RQ8] sample groups continue to the chirp's last sample, index up to 1023
// [RQ9] quality value goes out in 12-bit slices, last slice bits 63:60 zero padded
// [RQ10] the quality section is switched on or off by configuration
// [RQ11] serialized payload bytes are spread across the four data lanes
// [RQ12] fewer lanes may be used, several channels then share one lane
// [RQ13] the fast link only sends data from device to host, never commands
// [RQ14] asynchronous events reach the host on a dedicated event interrupt
// [RQ15] a fault from the radio controller drives a separate error output
// [RQ16] the host wakes the device by pulsing its active-low reset
// [RQ17] the host reference clock only starts after the device has woken
// [RQ18] once enabled the clock lane stays in high-speed mode continuously
// [RQ19] long packets carry a 16-bit checksum, headers a virtual channel tag
module radar_adc_csi2_framer
  import csi2_framer_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input  wire logic        clock_in,
  input  wire logic        reset_n_in,
  input  wire logic        csi_enable_in,
  input  wire logic [1:0]  lane_mode_in,
  input  wire logic [9:0]  lane_rate_mbps_in,
  input  wire logic [1:0]  vchan_in,
  input  wire logic [7:0]  chirps_per_frame_in,
  input  wire logic        cq_enable_in,
  input  wire logic        chirp_start_in,
  input  wire logic [5:0]  profile_in,
  input  wire logic [11:0] chirp_num_in,
  input  wire logic [9:0]  last_sample_in,
  input  wire logic [63:0] cq_data_in,
  input  wire logic        sample_valid_in,
  input  wire logic [23:0] sample_iq_in,
  output logic             sample_ready_out,
  input  wire logic        link_clk_in,
  input  wire logic        fault_in,
  input  wire logic        irq_ack_in,
  output logic [31:0]      lane_data_out,
  output logic [3:0]       lane_valid_out,
  output logic             clk_lane_hs_out,
  output logic             link_rate_ok_out,
  output logic             busy_out,
  output logic             host_event_irq_out,
  output logic             error_out,
  output logic             ref_clk_out
);
  localparam int WAKE_CYCLES = (`WAKE_TIME_NS * `CLK_FREQ_MHZ + 999) / 1000;

  // --------------------------------------------------------------------------
  // sample fifo and link clock edge finder
  // --------------------------------------------------------------------------
  logic        fifo_valid, fifo_pop;
  logic [23:0] fifo_data;
  logic        lk_s1_ff, lk_s2_ff, lk_s3_ff, link_edge;

  csi2_sample_fifo #(.WIDTH(24), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock_in      (clock_in),
    .reset_n_in    (reset_n_in),
    .in_valid_in   (sample_valid_in),
    .in_data_in    (sample_iq_in),
    .in_ready_out  (sample_ready_out),
    .out_valid_out (fifo_valid),
    .out_data_out  (fifo_data),
    .out_ready_in  (fifo_pop)
  );

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      {lk_s1_ff, lk_s2_ff, lk_s3_ff} <= 3'h0;
    end else begin
      {lk_s1_ff, lk_s2_ff, lk_s3_ff} <= {link_clk_in, lk_s1_ff, lk_s2_ff};
    end
  end
  assign link_edge = lk_s2_ff && !lk_s3_ff;

  function automatic logic [7:0] ecc_f(input logic [23:0] d);
    ecc_f = {2'b00, ^(d & `ECC_P5), ^(d & `ECC_P4), ^(d & `ECC_P3),
             ^(d & `ECC_P2), ^(d & `ECC_P1), ^(d & `ECC_P0)};
  endfunction

  function automatic logic [15:0] crc_f(input logic [15:0] c, input logic [7:0] b);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      r = (r[0] ^ b[i]) ? ((r >> 1) ^ `CRC_POLY) : (r >> 1);
    end
    crc_f = r;
  endfunction

  // --------------------------------------------------------------------------
  // packet builder
  // --------------------------------------------------------------------------
  pkt_state_e  state_ff, nxt_state;
  sect_e       sect_ff, nxt_sect;
  logic [11:0] idx_ff, nxt_idx;
  logic [1:0]  bcnt_ff, nxt_bcnt, phase_ff, nxt_phase;
  logic [15:0] crc_ff, nxt_crc, wc_ff, nxt_wc, frame_num_ff, nxt_frame_num;
  logic [7:0]  chirp_cnt_ff, nxt_chirp_cnt, cpf_ff, nxt_cpf;
  logic        frame_open_ff, nxt_frame_open, cq_en_ff, nxt_cq_en;
  logic [5:0]  prof_ff, nxt_prof;
  logic [11:0] cnum_ff, nxt_cnum, smp_last_ff, nxt_smp_last;
  logic [63:0] cq_ff, nxt_cq;
  logic        link_on, last_chirp, frame_done, byte_take, byte_avail, byte_fire;
  logic        byte_last, pair_end, pay_end;
  logic [7:0]  cur_byte, di;
  logic [15:0] sp_data;
  logic [11:0] w0, w1;
  logic [71:0] cq_ext;
  logic [23:0] hdr24;

  assign link_on    = clk_lane_hs_out && link_rate_ok_out;
  assign last_chirp = (9'(chirp_cnt_ff) + 9'h001) >= 9'(cpf_ff);
  assign cq_ext     = {8'h00, cq_ff};
  assign byte_fire  = byte_avail && byte_take;
  assign frame_done = byte_fire && byte_last && (state_ff == S_FE);

  always_comb begin
    w0 = '0;
    w1 = '0;
    unique case (sect_ff)
      SEC_HDR: begin
        w0[`HDR_CH_MSB:`HDR_CH_LSB]     = idx_ff[1:0]; // RQ5
        w0[`HDR_PROF_MSB:`HDR_PROF_LSB] = prof_ff;
        w1 = cnum_ff;
      end
      SEC_SMP: begin
        w0 = fifo_data[11:0]; // RQ7
        w1 = fifo_data[23:12];
      end
      SEC_CQ: begin
        {w1, w0} = cq_ext[24*idx_ff[1:0] +: 24]; // RQ9
      end
      default: ;
    endcase
    unique case (state_ff)
      S_FS:    di = {vchan_in, `DT_FRAME_START}; // RQ19
      S_FE:    di = {vchan_in, `DT_FRAME_END};
      S_LS:    di = {vchan_in, `DT_LINE_START};
      S_LE:    di = {vchan_in, `DT_LINE_END};
      default: di = {vchan_in, `DT_RAW12};
    endcase
    sp_data  = (state_ff == S_LHDR) ? wc_ff :
               ((state_ff == S_FS) || (state_ff == S_FE)) ? frame_num_ff : {8'h00, chirp_cnt_ff};
    hdr24    = {sp_data, di};
    cur_byte = 8'h00;
    unique case (state_ff)
      S_PAY:   cur_byte = (phase_ff == 2'd0) ? w0[11:4] :
                          (phase_ff == 2'd1) ? w1[11:4] : {w1[3:0], w0[3:0]};
      S_CRC:   cur_byte = (bcnt_ff == 2'd0) ? crc_ff[7:0] : crc_ff[15:8];
      S_IDLE:  cur_byte = 8'h00;
      default: cur_byte = (bcnt_ff == 2'd3) ? ecc_f(hdr24) : hdr24[8*bcnt_ff +: 8];
    endcase
    pair_end   = (phase_ff == 2'd2);
    pay_end    = pair_end && (((sect_ff == SEC_SMP) && (idx_ff == smp_last_ff) && !cq_en_ff) ||
                              ((sect_ff == SEC_CQ) && (idx_ff == 12'd2)));
    byte_avail = (state_ff != S_IDLE) && !((state_ff == S_PAY) && (sect_ff == SEC_SMP) && !fifo_valid);
    byte_last  = (state_ff == S_PAY) ? pay_end :
                 (state_ff == S_CRC) ? (bcnt_ff == 2'd1) : (bcnt_ff == 2'd3);
    fifo_pop   = byte_fire && (state_ff == S_PAY) && (sect_ff == SEC_SMP) && pair_end; // RQ6
  end

  always_comb begin
    nxt_state = state_ff;  nxt_sect = sect_ff;  nxt_idx = idx_ff;
    nxt_bcnt = bcnt_ff;  nxt_phase = phase_ff;  nxt_crc = crc_ff;  nxt_wc = wc_ff;
    nxt_frame_num = frame_num_ff;  nxt_chirp_cnt = chirp_cnt_ff;  nxt_cpf = cpf_ff;
    nxt_frame_open = frame_open_ff;  nxt_cq_en = cq_en_ff;  nxt_prof = prof_ff;
    nxt_cnum = cnum_ff;  nxt_smp_last = smp_last_ff;  nxt_cq = cq_ff;
    if ((state_ff == S_IDLE) && chirp_start_in && link_on) begin
      nxt_prof     = profile_in;
      nxt_cnum     = chirp_num_in;
      nxt_cq       = cq_data_in;
      nxt_cq_en    = cq_enable_in; // RQ10
      nxt_smp_last = {last_sample_in, 2'b11}; // RQ8
      nxt_wc       = 16'(({4'h0, last_sample_in, 2'b00} + 16'd8 + (cq_enable_in ? 16'd3 : 16'd0)) * 16'd3);
      nxt_bcnt     = 2'd0;
      if (!frame_open_ff) begin
        nxt_cpf   = chirps_per_frame_in;
        nxt_state = S_FS; // RQ2
      end else begin
        nxt_state = S_LS; // RQ3
      end
    end else if (byte_fire) begin
      nxt_bcnt = 2'(bcnt_ff + 2'd1);
      if (state_ff == S_PAY) begin
        nxt_crc   = crc_f(crc_ff, cur_byte); // RQ19
        nxt_phase = pair_end ? 2'd0 : 2'(phase_ff + 2'd1);
        if (pair_end) begin
          nxt_idx = 12'(idx_ff + 12'd1);
          if ((sect_ff == SEC_HDR) && (idx_ff == 12'd3)) begin
            nxt_sect = SEC_SMP; // RQ4
            nxt_idx  = '0;
          end else if ((sect_ff == SEC_SMP) && (idx_ff == smp_last_ff)) begin
            nxt_sect = SEC_CQ; // RQ9
            nxt_idx  = '0;
          end
        end
      end
      if (byte_last) begin
        nxt_bcnt = 2'd0;
        unique case (state_ff)
          S_FS:   begin nxt_state = S_LS; nxt_frame_open = 1'b1; nxt_chirp_cnt = '0; end
          S_LS:   nxt_state = S_LHDR; // RQ3
          S_LHDR: begin
            nxt_state = S_PAY;
            nxt_sect  = SEC_HDR; // RQ4
            nxt_idx   = '0;
            nxt_phase = 2'd0;
            nxt_crc   = `CRC_INIT;
          end
          S_PAY:  nxt_state = S_CRC; // RQ19
          S_CRC:  nxt_state = S_LE; // RQ3
          S_LE:   begin
            nxt_chirp_cnt = 8'(chirp_cnt_ff + 8'd1);
            nxt_state     = last_chirp ? S_FE : S_IDLE; // RQ2
          end
          S_FE:   begin
            nxt_state      = S_IDLE;
            nxt_frame_open = 1'b0;
            nxt_frame_num  = 16'(frame_num_ff + 16'd1);
          end
          S_IDLE: nxt_state = S_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      state_ff <= S_IDLE;  sect_ff <= SEC_HDR;  idx_ff <= '0;  bcnt_ff <= '0;
      phase_ff <= '0;  crc_ff <= `CRC_INIT;  wc_ff <= '0;  frame_num_ff <= '0;
      chirp_cnt_ff <= '0;  cpf_ff <= '0;  frame_open_ff <= 1'b0;  cq_en_ff <= 1'b0;
      prof_ff <= '0;  cnum_ff <= '0;  smp_last_ff <= '0;  cq_ff <= '0;
    end else begin
      state_ff <= nxt_state;  sect_ff <= nxt_sect;  idx_ff <= nxt_idx;  bcnt_ff <= nxt_bcnt;
      phase_ff <= nxt_phase;  crc_ff <= nxt_crc;  wc_ff <= nxt_wc;
      frame_num_ff <= nxt_frame_num;  chirp_cnt_ff <= nxt_chirp_cnt;  cpf_ff <= nxt_cpf;
      frame_open_ff <= nxt_frame_open;  cq_en_ff <= nxt_cq_en;  prof_ff <= nxt_prof;
      cnum_ff <= nxt_cnum;  smp_last_ff <= nxt_smp_last;  cq_ff <= nxt_cq;
    end
  end

  // --------------------------------------------------------------------------
  // lane distributor: lanes only ever send, nothing is read back
  // --------------------------------------------------------------------------
  logic [31:0] gather_ff, nxt_gather, nxt_lane_data;
  logic [2:0]  gcnt_ff, nxt_gcnt, lanes_ff, nxt_lanes;
  logic        flush_ff, nxt_flush, send;
  logic [3:0]  nxt_lane_valid;

  assign byte_take = (gcnt_ff < lanes_ff) && !flush_ff;
  assign send      = link_edge && ((gcnt_ff == lanes_ff) || flush_ff);

  always_comb begin
    nxt_gather     = gather_ff;
    nxt_gcnt       = gcnt_ff;
    nxt_flush      = flush_ff;
    nxt_lane_data  = lane_data_out;
    nxt_lane_valid = link_edge ? 4'h0 : lane_valid_out;
    // lane count is only changed between packets so a packet never splits unevenly
    nxt_lanes      = lanes_ff;
    if ((state_ff == S_IDLE) && (gcnt_ff == 3'd0)) begin
      nxt_lanes = (lane_mode_in == 2'd0) ? 3'd1 : (lane_mode_in == 2'd1) ? 3'd2 : 3'd4; // RQ12
    end
    if (byte_fire) begin
      nxt_gather[8*gcnt_ff[1:0] +: 8] = cur_byte; // RQ11
      nxt_gcnt  = 3'(gcnt_ff + 3'd1);
      nxt_flush = byte_last;
    end
    if (send) begin
      nxt_lane_data  = gather_ff; // RQ13
      nxt_lane_valid = 4'(5'h0f >> (3'd4 - gcnt_ff));
      nxt_gcnt       = 3'd0;
      nxt_flush      = 1'b0;
    end
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      gather_ff <= '0;  gcnt_ff <= '0;  flush_ff <= 1'b0;  lanes_ff <= 3'd4;
      lane_data_out <= '0;  lane_valid_out <= '0;
    end else begin
      gather_ff <= nxt_gather;  gcnt_ff <= nxt_gcnt;  flush_ff <= nxt_flush;
      lanes_ff <= nxt_lanes;  lane_data_out <= nxt_lane_data;  lane_valid_out <= nxt_lane_valid;
    end
  end

  // --------------------------------------------------------------------------
  // sideband: wake, reference clock, clock lane, events, error
  // --------------------------------------------------------------------------
  logic [$clog2(WAKE_CYCLES+1)-1:0] wake_cnt_ff, nxt_wake_cnt;
  logic [2:0] ref_cnt_ff, nxt_ref_cnt;
  logic       woke_ff, nxt_woke, nxt_ref_clk, nxt_hs, nxt_rate_ok, nxt_irq, nxt_err;

  always_comb begin
    nxt_woke     = woke_ff || (wake_cnt_ff == ($bits(wake_cnt_ff))'(WAKE_CYCLES - 1));
    nxt_wake_cnt = woke_ff ? wake_cnt_ff : ($bits(wake_cnt_ff))'(wake_cnt_ff + 1'b1);
    nxt_ref_cnt  = ref_cnt_ff;
    nxt_ref_clk  = ref_clk_out;
    if (woke_ff) begin // RQ17
      nxt_ref_cnt = (ref_cnt_ff == 3'(`REF_HALF_CYCLES - 1)) ? 3'd0 : 3'(ref_cnt_ff + 3'd1);
      nxt_ref_clk = (ref_cnt_ff == 3'(`REF_HALF_CYCLES - 1)) ? !ref_clk_out : ref_clk_out;
    end
    nxt_hs      = clk_lane_hs_out || csi_enable_in; // RQ18
    nxt_rate_ok = (lane_rate_mbps_in >= `RATE_MIN_MBPS) &&
                  (lane_rate_mbps_in <= `RATE_MAX_MBPS); // RQ1
    // a frame completing in the ack cycle keeps the interrupt raised
    nxt_irq     = frame_done || (host_event_irq_out && !irq_ack_in); // RQ14
    nxt_err     = fault_in; // RQ15
  end

  always_ff @(posedge clock_in or negedge reset_n_in) begin
    if (!reset_n_in) begin // RQ16
      wake_cnt_ff <= '0;  woke_ff <= 1'b0;  ref_cnt_ff <= '0;  ref_clk_out <= 1'b0;
      clk_lane_hs_out <= 1'b0;  link_rate_ok_out <= 1'b0;  host_event_irq_out <= 1'b0;
      error_out <= 1'b0;  busy_out <= 1'b0;
    end else begin
      wake_cnt_ff <= nxt_wake_cnt;  woke_ff <= nxt_woke;  ref_cnt_ff <= nxt_ref_cnt;
      ref_clk_out <= nxt_ref_clk;  clk_lane_hs_out <= nxt_hs;  link_rate_ok_out <= nxt_rate_ok;
      host_event_irq_out <= nxt_irq;  error_out <= nxt_err;  busy_out <= (nxt_state != S_IDLE);
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);

  chk_rate_window: assert property ( // RQ1
    (lane_rate_mbps_in > `RATE_MAX_MBPS) |=> !link_rate_ok_out) else $error("rate outside window");
  chk_frame_open: assert property ( // RQ2
    (state_ff == S_IDLE && chirp_start_in && link_on && !frame_open_ff) |=> state_ff == S_FS)
    else $error("frame start missing");
  chk_frame_close: assert property ( // RQ2
    (state_ff == S_LE && byte_fire && byte_last && last_chirp) |=> state_ff == S_FE)
    else $error("frame end missing");
  chk_line_bracket: assert property ( // RQ3
    (state_ff == S_CRC && byte_fire && byte_last) |=> state_ff == S_LE)
    else $error("line end missing");
  chk_pay_start: assert property ( // RQ5
    (state_ff == S_LHDR && byte_fire && byte_last) |=> (sect_ff == SEC_HDR && idx_ff == 0 &&
    phase_ff == 0 && crc_ff == `CRC_INIT)) else $error("payload does not open with header");
  chk_pop_phase: assert property ( // RQ7
    fifo_pop |-> (sect_ff == SEC_SMP && phase_ff == 2'd2)) else $error("sample pop misplaced");
  chk_smp_bound: assert property ( // RQ8
    (sect_ff == SEC_SMP && state_ff == S_PAY) |-> idx_ff <= smp_last_ff)
    else $error("sample index overrun");
  chk_cq_gate: assert property ( // RQ10
    (state_ff == S_PAY && sect_ff == SEC_CQ) |-> cq_en_ff) else $error("quality sent while off");
  chk_lane_mask: assert property ( // RQ12
    (lane_valid_out & ~4'(5'h0f >> (3'd4 - lanes_ff))) == 4'h0) else $error("lane beyond count");
  chk_hs_hold: assert property ( // RQ18
    clk_lane_hs_out |=> clk_lane_hs_out [*8]) else $error("clock lane left high speed");
  chk_ref_wake: assert property ( // RQ17
    !woke_ff |-> !ref_clk_out) else $error("reference clock before wake");
  chk_irq_raise: assert property ( // RQ14
    frame_done |=> host_event_irq_out) else $error("event interrupt not raised");
  chk_err_follow: assert property ( // RQ15
    fault_in |=> error_out) else $error("error not reported");

  cov_frame_start: cover property (state_ff == S_FS ##1 state_ff == S_LS);
  cov_cq_sent:     cover property (state_ff == S_PAY && sect_ff == SEC_CQ && pay_end);
  cov_smp_stall:   cover property (state_ff == S_PAY && sect_ff == SEC_SMP && !fifo_valid);
  cov_frame_end:   cover property (frame_done);

endmodule // radar_adc_csi2_framer

// ---- test/host_phy_model.sv ----
// host receiver model: free-running lane byte clock and lane beat capture
`timescale 1ns/100ps
module host_phy_model (
  output logic             link_clk_out,
  input  wire logic [31:0] lane_data_in,
  input  wire logic [3:0]  lane_valid_in
);
  logic [35:0] rx_q[$];
  // clock lane stays in high speed, so the byte clock runs between frames too
  initial begin
    link_clk_out = 1'b0;
    #13;
    forever #40 link_clk_out = ~link_clk_out;
  end
  // sample mid-beat: lanes settle about 22 ns after the rise
  always @(posedge link_clk_out) begin
    #60;
    if (lane_valid_in != 4'h0) rx_q.push_back({lane_valid_in, lane_data_in});
  end
endmodule  // host_phy_model

// ---- test/tb_top.sv ----
// testbench: chirp frames checked byte by byte at the host receiver model
`timescale 1ns/100ps
module tb_top;
  logic        clock_in = 1'b0, reset_n_in = 1'b0, csi_enable_in = 1'b0, cq_enable_in = 1'b0;
  logic        chirp_start_in = 1'b0, sample_valid_in = 1'b0, fault_in = 1'b0, irq_ack_in = 1'b0;
  logic [1:0]  lane_mode_in = 2'h0, vchan_in = 2'h0;
  logic [9:0]  lane_rate_mbps_in = 10'h064, last_sample_in = 10'h000;
  logic [7:0]  chirps_per_frame_in = 8'h01;
  logic [5:0]  profile_in = 6'h00;
  logic [11:0] chirp_num_in = 12'h000;
  logic [63:0] cq_data_in = 64'h0;
  logic [23:0] sample_iq_in = 24'h0;
  logic        sample_ready_out, link_clk_in, clk_lane_hs_out, link_rate_ok_out, busy_out;
  logic        host_event_irq_out, error_out, ref_clk_out, r;
  logic [31:0] lane_data_out;
  logic [3:0]  lane_valid_out;
  logic [8:0]  exp_q[$];
  int          n_errors = 0, cmp_count = 0, seed = 24;
  always #5 clock_in = ~clock_in;
  radar_adc_csi2_framer #(.FIFO_DEPTH(8)) u_radar_adc_csi2_framer (.clock_in, .reset_n_in,
    .csi_enable_in, .lane_mode_in, .lane_rate_mbps_in, .vchan_in, .chirps_per_frame_in,
    .cq_enable_in, .chirp_start_in, .profile_in, .chirp_num_in, .last_sample_in, .cq_data_in,
    .sample_valid_in, .sample_iq_in, .sample_ready_out, .link_clk_in, .fault_in, .irq_ack_in,
    .lane_data_out, .lane_valid_out, .clk_lane_hs_out, .link_rate_ok_out, .busy_out,
    .host_event_irq_out, .error_out, .ref_clk_out);
  host_phy_model u_host_phy_model (.link_clk_out(link_clk_in), .lane_data_in(lane_data_out),
    .lane_valid_in(lane_valid_out));
  task automatic check(input logic [35:0] got, input logic [35:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("errors=%0d compares=%0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // one word pair packs into three bytes; bit 8 set marks a byte not compared
  function automatic void pair(input logic [11:0] w0, input logic [11:0] w1);
    exp_q.push_back({1'b0, w0[11:4]});
    exp_q.push_back({1'b0, w1[11:4]});
    exp_q.push_back({1'b0, w1[3:0], w0[3:0]});
  endfunction
  function automatic void sp(input logic [5:0] dt, input int n);
    exp_q.push_back({1'b0, vchan_in, dt});
    repeat (n) exp_q.push_back(9'h100);
  endfunction
  task automatic push(input logic [23:0] w);
    logic ok;
    sample_valid_in <= 1'b1;
    sample_iq_in <= w;
    do begin
      @(negedge clock_in) ok = sample_ready_out;
      @(posedge clock_in);
    end while (ok !== 1'b1);
  endtask
  task automatic frame(input logic [1:0] mode, input logic cq);
    logic [23:0] w;
    logic [63:0] q;
    logic [15:0] wc;
    logic [7:0]  got_q[$];
    logic [3:0]  vm;
    @(posedge clock_in);
    u_host_phy_model.rx_q.delete();
    exp_q.delete();
    lane_mode_in <= mode;
    cq_enable_in <= cq;
    profile_in <= 6'($random(seed));
    chirp_num_in <= 12'($random(seed));
    last_sample_in <= 10'(1 + ($random(seed) & 3));
    cq_data_in <= {$random(seed), $random(seed)};
    @(posedge clock_in);
    chirp_start_in <= 1'b1;
    @(posedge clock_in);
    chirp_start_in <= 1'b0;
    q = cq_data_in;
    // four header pairs, four sample pairs per index, three quality pairs
    wc = 16'(3 * (4 + 4 * (last_sample_in + 1) + 3 * cq));
    sp(6'h00, 3);
    sp(6'h02, 3);
    sp(6'h2c, 0);
    exp_q.push_back({1'b0, wc[7:0]});
    exp_q.push_back({1'b0, wc[15:8]});
    exp_q.push_back(9'h100);
    for (int c = 0; c < 4; c++) pair({profile_in, 4'h0, 2'(c)}, chirp_num_in);
    for (int i = 0; i < 4 * (last_sample_in + 1); i++) begin
      w = 24'($random(seed));
      pair(w[11:0], w[23:12]);
      push(w);
    end
    sample_valid_in <= 1'b0;
    if (cq) begin
      pair(q[11:0], q[23:12]);
      pair(q[35:24], q[47:36]);
      pair(q[59:48], {8'h00, q[63:60]});
    end
    exp_q.push_back(9'h100);
    exp_q.push_back(9'h100);
    sp(6'h03, 3);
    sp(6'h01, 3);
    while (busy_out !== 1'b0) @(negedge clock_in);
    repeat (24) @(negedge clock_in);
    // unfold each beat lane by lane so every lane count is checked byte for byte
    foreach (u_host_phy_model.rx_q[b])
      for (int k = 0; k < 4; k++)
        if (u_host_phy_model.rx_q[b][32+k])
          got_q.push_back(u_host_phy_model.rx_q[b][8*k +: 8]);
    check(36'(got_q.size()), 36'(exp_q.size()));
    foreach (exp_q[i]) if (!exp_q[i][8] && i < got_q.size())
      check(got_q[i], exp_q[i][7:0]);
    vm = (mode == 2'h0) ? 4'h1 : (mode == 2'h1) ? 4'h3 : 4'hf;
    check(u_host_phy_model.rx_q[0][35:32], vm);
  endtask
  initial begin
    repeat (4) @(posedge clock_in);
    reset_n_in <= 1'b1;
    repeat (3) @(negedge clock_in);
    check(link_rate_ok_out, 1'b0);
    @(posedge clock_in);
    lane_rate_mbps_in <= 10'h096;
    csi_enable_in <= 1'b1;
    vchan_in <= 2'($random(seed));
    repeat (3) @(negedge clock_in);
    check({clk_lane_hs_out, link_rate_ok_out, ref_clk_out}, 3'b110);
    frame(2'h0, 1'b1);
    check(host_event_irq_out, 1'b1);
    @(posedge clock_in);
    irq_ack_in <= 1'b1;
    @(posedge clock_in);
    irq_ack_in <= 1'b0;
    repeat (2) @(negedge clock_in);
    check(host_event_irq_out, 1'b0);
    frame(2'h0, 1'b0);
    frame(2'h2, 1'($random(seed)));
    frame(2'h1, 1'($random(seed)));
    @(posedge clock_in);
    fault_in <= 1'b1;
    lane_rate_mbps_in <= 10'h259;
    repeat (3) @(negedge clock_in);
    check({error_out, link_rate_ok_out, clk_lane_hs_out}, 3'b101);
    r = ref_clk_out;
    repeat (4) @(negedge clock_in);
    check(ref_clk_out, !r);
    complete_run();
  end
  initial begin
    #200us;
    n_errors++;
    complete_run();
  end
endmodule  // tb_top
